// File: common/dmt_chan_if.sv
interface dmt_chan_if;
  import dmt_pkg::*;

  logic             enable;
  logic             ext_sel;
  logic             event_pulse;
  logic             restart;
  logic [PRE_W-1:0] prescale;
  logic [CNT_W-1:0] ref_val;
  logic [CNT_W-1:0] count;
  logic             match;

  modport ctl (
    output enable,
    output ext_sel,
    output event_pulse,
    output restart,
    output prescale,
    output ref_val,
    input  count,
    input  match
  );

  modport chan (
    input  enable,
    input  ext_sel,
    input  event_pulse,
    input  restart,
    input  prescale,
    input  ref_val,
    output count,
    output match
  );

endinterface : dmt_chan_if

// File: common/dmt_pkg.sv
package dmt_pkg;

  localparam int NUM_TMR = 2;
  localparam int CNT_W   = 16;
  localparam int PRE_W   = 8;
  localparam int ADDR_W  = 8;
  localparam int DATA_W  = 32;

  // Byte offsets inside one timer's block, the stride between timers, and the shared words
  localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_PRE    = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_REF    = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_CAP    = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_CNT    = 8'h10;
  localparam logic [ADDR_W-1:0] TMR_STRIDE = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h40;
  localparam logic [ADDR_W-1:0] OFS_MASK   = 8'h44;

  // Control register field positions
  localparam int CTRL_W       = 8;
  localparam int CTRL_EN      = 0;
  localparam int CTRL_EXT     = 1;
  localparam int CTRL_CAP     = 2;
  localparam int CTRL_OUTEN   = 3;
  localparam int CTRL_TOGGLE  = 4;
  localparam int CTRL_EDGE    = 5;
  localparam int CTRL_RESTART = 7;

  // Status and mask bit positions
  localparam int ST_W    = 3;
  localparam int ST_REF0 = 0;
  localparam int ST_REF1 = 1;
  localparam int ST_CAP0 = 2;

  // Values after reset
  localparam logic [CTRL_W-1:0] CTRL_RST = 8'h00;
  localparam logic [PRE_W-1:0]  PRE_RST  = 8'h00;
  localparam logic [CNT_W-1:0]  REF_RST  = 16'hFFFF;
  localparam logic [CNT_W-1:0]  CNT_RST  = 16'h0000;
  localparam logic [ST_W-1:0]   ST_RST   = 3'h0;
  localparam logic [ST_W-1:0]   MASK_RST = 3'h0;

  // Clock period; prescale 0 gives one count per period
  localparam int CLK_PERIOD_NS = 8;

  typedef enum logic [1:0] {
    EDGE_OFF,
    EDGE_RISE,
    EDGE_FALL,
    EDGE_BOTH
  } dmt_edge_e;

endpackage : dmt_pkg

// File: design/dmt_chan.sv
module dmt_chan
  import dmt_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic rst_in,
  dmt_chan_if.chan  ch
);

  logic [PRE_W-1:0] pre_cnt;
  logic [CNT_W-1:0] count;
  logic             tick_q;
  logic             match_q;

  // External events replace the clock as prescaler input
  wire logic src      = ch.ext_sel ? ch.event_pulse : 1'b1;
  // At or past the limit, so a smaller prescale never stalls a lap
  wire logic pre_done = (pre_cnt >= ch.prescale);
  wire logic tick     = ch.enable & src & pre_done;
  wire logic at_ref   = (count == ch.ref_val);
  wire logic hit      = tick_q & at_ref & ~match_q;

  // Divide by prescale+1 of the selected source
  always_ff @(posedge clk_in) begin
    if (rst_in || !ch.enable) begin
      pre_cnt <= PRE_RST;
    end else if (src) begin
      pre_cnt <= pre_done ? PRE_RST : pre_cnt + 8'h01;
    end
  end

  // Free running unless restart clears it at the reference; wraps at all ones without software help
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      count <= CNT_RST;
    end else if (tick && ch.restart && at_ref) begin
      count <= CNT_RST;
    end else if (tick) begin
      count <= count + 16'h0001;
    end
  end

  // Match fires once per arrival at the reference, not while parked
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      tick_q  <= 1'b0;
      match_q <= 1'b0;
    end else begin
      tick_q  <= tick;
      match_q <= hit;
    end
  end

  assign ch.count = count;
  assign ch.match = hit;

endmodule : dmt_chan

// File: design/dmt_top.sv
module dmt_top
  import dmt_pkg::*;
(
  input  wire logic              REF_CLK_IN,
  input  wire logic              RESET_IN,
  input  wire logic [ADDR_W-1:0] ADDR_IN,
  input  wire logic [DATA_W-1:0] WR_DATA_IN,
  input  wire logic              WR_STROBE_IN,
  input  wire logic              RD_STROBE_IN,
  input  wire logic              TIMER_EVENT_INPUT_IN,
  output logic      [DATA_W-1:0] RD_DATA_OUT,
  output logic                   TIMER_OUT_N_OUT,
  output logic                   IRQ_OUT
);

  logic [CTRL_W-1:0] ctrl     [NUM_TMR];
  logic [PRE_W-1:0]  prescale [NUM_TMR];
  logic [CNT_W-1:0]  ref_val  [NUM_TMR];
  logic [CNT_W-1:0]  capture;
  logic [ST_W-1:0]   status;
  logic [ST_W-1:0]   mask;
  logic              ev_meta;
  logic              ev_sync;
  logic              ev_prev;
  logic              pin;
  logic              irq;
  logic [DATA_W-1:0] rd_data;

  wire logic [DATA_W-1:0] rd_part [NUM_TMR];
  wire logic              match   [NUM_TMR];

  dmt_chan_if chif [NUM_TMR] ();

  // Pin synchroniser; only the second and third stages are looked at
  always_ff @(posedge REF_CLK_IN) begin
    if (RESET_IN) begin
      ev_meta <= 1'b0;
      ev_sync <= 1'b0;
      ev_prev <= 1'b0;
    end else begin
      ev_meta <= TIMER_EVENT_INPUT_IN;
      ev_sync <= ev_meta;
      ev_prev <= ev_sync;
    end
  end

  wire logic      ev_rise = ev_sync & ~ev_prev;
  wire logic      ev_fall = ~ev_sync & ev_prev;
  wire dmt_edge_e edge_sel = dmt_edge_e'(ctrl[0][CTRL_EDGE +: 2]);
  wire logic      ev_hit =
      ((edge_sel == EDGE_RISE) & ev_rise) |
      ((edge_sel == EDGE_FALL) & ev_fall) |
      ((edge_sel == EDGE_BOTH) & (ev_rise | ev_fall));

  // Register decode for the shared words
  wire logic wr_status = WR_STROBE_IN & (ADDR_IN == OFS_STATUS);
  wire logic wr_mask   = WR_STROBE_IN & (ADDR_IN == OFS_MASK);
  wire logic rd_status = (ADDR_IN == OFS_STATUS);
  wire logic rd_mask   = (ADDR_IN == OFS_MASK);

  for (genvar i = 0; i < NUM_TMR; i++) begin : g_tmr
    localparam logic [ADDR_W-1:0] BASE = ADDR_W'(i * 32);

    wire logic sel_ctrl = (ADDR_IN == BASE + OFS_CTRL);
    wire logic sel_pre  = (ADDR_IN == BASE + OFS_PRE);
    wire logic sel_ref  = (ADDR_IN == BASE + OFS_REF);
    wire logic sel_cap  = (ADDR_IN == BASE + OFS_CAP) && (i == 0);
    wire logic sel_cnt  = (ADDR_IN == BASE + OFS_CNT);

    // Second timer is purely internal: no pin events, no capture
    wire logic [CTRL_W-1:0] ctrl_mask =
        (i == 0) ? 8'hFF : 8'h99;

    always_ff @(posedge REF_CLK_IN) begin
      if (RESET_IN) begin
        ctrl[i]     <= CTRL_RST;
        prescale[i] <= PRE_RST;
        ref_val[i]  <= REF_RST;
      end else if (WR_STROBE_IN) begin
        if (sel_ctrl) begin
          ctrl[i] <= WR_DATA_IN[CTRL_W-1:0] & ctrl_mask;
        end
        if (sel_pre) begin
          prescale[i] <= WR_DATA_IN[PRE_W-1:0];
        end
        if (sel_ref) begin
          ref_val[i] <= WR_DATA_IN[CNT_W-1:0];
        end
      end
    end

    assign chif[i].enable      = ctrl[i][CTRL_EN];
    assign chif[i].ext_sel     = ctrl[i][CTRL_EXT];
    assign chif[i].event_pulse = (i == 0) ? ev_hit : 1'b0;
    assign chif[i].restart     = ctrl[i][CTRL_RESTART];
    assign chif[i].prescale    = prescale[i];
    assign chif[i].ref_val     = ref_val[i];
    assign match[i]            = chif[i].match;

    assign rd_part[i] =
        ({DATA_W{sel_ctrl}} & {24'h0000_00, ctrl[i]}) |
        ({DATA_W{sel_pre}}  & {24'h0000_00, prescale[i]}) |
        ({DATA_W{sel_ref}}  & {16'h0000, ref_val[i]}) |
        ({DATA_W{sel_cap}}  & {16'h0000, capture}) |
        ({DATA_W{sel_cnt}}  & {16'h0000, chif[i].count});

    dmt_chan u_chan (
      .clk_in (REF_CLK_IN),
      .rst_in (RESET_IN),
      .ch     (chif[i])
    );
  end

  // Capture on the qualified pin event of the first timer
  wire logic cap_hit = ctrl[0][CTRL_CAP] & ev_hit;

  always_ff @(posedge REF_CLK_IN) begin
    if (RESET_IN) begin
      capture <= CNT_RST;
    end else if (cap_hit) begin
      capture <= chif[0].count;
    end
  end

  // Sticky events; a new event beats a same-cycle clear
  wire logic [ST_W-1:0] st_set  = {cap_hit, match[1], match[0]};
  wire logic [ST_W-1:0] st_clr  =
      wr_status ? WR_DATA_IN[ST_W-1:0] : ST_RST;
  wire logic [ST_W-1:0] next_status = (status & ~st_clr) | st_set;
  wire logic            next_irq    = |(next_status & mask);

  always_ff @(posedge REF_CLK_IN) begin
    if (RESET_IN) begin
      status <= ST_RST;
      mask   <= MASK_RST;
      irq    <= 1'b0;
    end else begin
      status <= next_status;
      irq    <= next_irq;
      if (wr_mask) begin
        mask <= WR_DATA_IN[ST_W-1:0];
      end
    end
  end

  // Output pin idles high outside toggle mode, where it holds its level; pulse is one clock low
  wire logic out_en     = ctrl[0][CTRL_OUTEN];
  wire logic out_toggle = ctrl[0][CTRL_TOGGLE];
  wire logic next_pin   =
      !out_en     ? 1'b1 :
      match[0]    ? (out_toggle ? ~pin : 1'b0) :
      out_toggle  ? pin : 1'b1;

  always_ff @(posedge REF_CLK_IN) begin
    if (RESET_IN) begin
      pin <= 1'b1;
    end else begin
      pin <= next_pin;
    end
  end

  // Unmapped reads return zero; data only in the cycle after the strobe
  wire logic [DATA_W-1:0] next_rd_data =
      rd_part[0] | rd_part[1] |
      ({DATA_W{rd_status}} & {29'h0000_0000, status}) |
      ({DATA_W{rd_mask}}   & {29'h0000_0000, mask});

  always_ff @(posedge REF_CLK_IN) begin
    if (RESET_IN) begin
      rd_data <= 32'h0000_0000;
    end else begin
      rd_data <= RD_STROBE_IN ? next_rd_data : 32'h0000_0000;
    end
  end

  assign RD_DATA_OUT     = rd_data;
  assign TIMER_OUT_N_OUT = pin;
  assign IRQ_OUT         = irq;

endmodule : dmt_top

// File: verif/dmt_chk.sv
module dmt_chk
  import dmt_pkg::*;
(
  input wire logic              REF_CLK_IN,
  input wire logic              RESET_IN,
  input wire logic [ADDR_W-1:0] ADDR_IN,
  input wire logic              RD_STROBE_IN,
  input wire logic [DATA_W-1:0] RD_DATA_OUT
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge REF_CLK_IN); endclocking
  default disable iff (RESET_IN);
  wire              rd = RD_STROBE_IN;
  wire [ADDR_W-1:0] a  = ADDR_IN;
  wire [DATA_W-1:0] q  = RD_DATA_OUT;
  a_count_width: assert property (
    rd && a == OFS_CNT |=> q[31:16] == '0) else $error("count too wide");
  a_ref_width: assert property (
    rd && a == OFS_REF |=> q[31:16] == '0) else $error("ref too wide");
  a_capture_width: assert property (
    rd && a == OFS_CAP |=> q[31:16] == '0) else $error("capture too wide");
  a_prescale_width: assert property (
    rd && a == TMR_STRIDE + OFS_PRE |=> q[31:8] == '0)
    else $error("prescale too wide");
  a_no_capture_t1: assert property (
    rd && a == TMR_STRIDE + OFS_CAP |=> q == '0)
    else $error("second timer shows a capture");
  a_t1_no_pins: assert property (
    rd && a == TMR_STRIDE + OFS_CTRL |=> q[6:5] == '0 && q[2:1] == '0)
    else $error("second timer keeps pin bits");
  a_status_width: assert property (
    rd && a == OFS_STATUS |=> q[31:ST_W] == '0)
    else $error("status too wide");
  a_read_idle: assert property (
    !rd |=> q == '0) else $error("read data not idle");
endmodule : dmt_chk

bind dmt_top dmt_chk dmt_chk_inst (.REF_CLK_IN, .RESET_IN, .ADDR_IN,
  .RD_STROBE_IN, .RD_DATA_OUT);

// File: verif/dmt_ev_src.sv
module dmt_ev_src (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       go_in,
  input  wire logic [3:0] num_in,
  input  wire logic [3:0] half_in,
  output logic            ev_out,
  output logic            busy_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] left;
  logic [3:0] ph;
  assign busy_out = (left != 5'h00);
  // Idles low; half_in sets a prompt or slow source
  always @(posedge clk_in) begin
    if (rst_in) begin
      left   <= 5'h00;
      ph     <= 4'h0;
      ev_out <= 1'b0;
    end else if (go_in) begin
      left <= {num_in, 1'b0};
      ph   <= half_in;
    end else if (busy_out && ph == 4'h1) begin
      ev_out <= ~ev_out;
      left   <= left - 5'h01;
      ph     <= half_in;
    end else if (busy_out) begin
      ph <= ph - 4'h1;
    end
  end
endmodule : dmt_ev_src

// File: verif/tb.sv
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
  num_errors++; $display("wrong value %s exp %0h got %0h", nm, e, g); end end

module tb
  import dmt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic              clk = 1'b0, rst = 1'b1, wr = 1'b0, rs = 1'b0, go = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0, q, d, c0;
  logic [3:0]        half = 4'h2;
  logic [15:0]       c;
  logic              ev, busy, pin_n, irq;
  int                num_errors = 0, cmp_count = 0, seed = 32'h083a;
  int                r, p, g, n;

  always #4 clk = ~clk;

  dmt_top dmt_top_inst (.REF_CLK_IN(clk), .RESET_IN(rst), .ADDR_IN(addr),
    .WR_DATA_IN(wdata), .WR_STROBE_IN(wr), .RD_STROBE_IN(rs),
    .TIMER_EVENT_INPUT_IN(ev), .RD_DATA_OUT(q), .TIMER_OUT_N_OUT(pin_n),
    .IRQ_OUT(irq));
  dmt_ev_src dmt_ev_src_inst (.clk_in(clk), .rst_in(rst), .go_in(go),
    .num_in(4'h5), .half_in(half), .ev_out(ev), .busy_out(busy));

  function automatic int ev_exp(input int e, input int k);
    return (e == 0) ? 0 : (e == 3) ? 2 * k : k;
  endfunction : ev_exp

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    rs <= 1'b1;
    addr <= a;
    @(posedge clk);
    rs <= 1'b0;
    #1 v = q;
  endtask : rd_reg

  task automatic span(input logic [7:0] a, input int k, output logic [15:0] v);
    rd_reg(a, c0);
    repeat (k - 2) @(posedge clk);
    rd_reg(a, d);
    v = 16'(d - c0);
  endtask : span

  // Third pass: first fall may sit on a mode change
  task automatic fall_gap(output int k);
    logic prev;
    repeat (3) begin
      k = 0;
      do begin
        prev = pin_n;
        @(posedge clk);
        #1 k++;
      end while (!(prev === 1'b1 && pin_n === 1'b0) && k < 300);
    end
  endtask : fall_gap

  task automatic results;
    $display("compared %0d, wrong %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results

  initial begin
    repeat (90000) @(posedge clk);
    num_errors++;
    results();
  end

  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd_reg(OFS_REF, d);
    `CHK("ref reset", {16'h0000, REF_RST}, d)
    r = 3 + $unsigned($random(seed)) % 12;
    wr_reg(OFS_REF, DATA_W'(r));
    wr_reg(OFS_MASK, 32'h0000_0001);
    wr_reg(OFS_CTRL, 32'h0000_0089);
    fall_gap(g);
    `CHK("pulse gap", r + 1, g)
    @(posedge clk);
    #1 `CHK("pulse end", 1'b1, pin_n)
    `CHK("irq set", 1'b1, irq)
    wr_reg(OFS_CTRL, 32'h0000_0099);
    fall_gap(g);
    `CHK("toggle gap", 2 * r + 2, g)
    rd_reg(OFS_STATUS, d);
    `CHK("ref flag", 1'b1, d[ST_REF0])
    wr_reg(OFS_MASK, 32'h0000_0000);
    wr_reg(OFS_CTRL, 32'h0000_0000);
    #1 `CHK("irq masked", 1'b0, irq)
    wr_reg(OFS_STATUS, 32'h0000_0007);
    rd_reg(OFS_STATUS, d);
    `CHK("flags clear", 32'h0000_0000, d)
    $display("test pin done");
    p = $unsigned($random(seed)) % 8;
    wr_reg(OFS_PRE, DATA_W'(p));
    wr_reg(OFS_CTRL, 32'h0000_0001);
    span(OFS_CNT, (p + 1) * 8, c);
    `CHK("prescale", 16'h0008, c)
    wr_reg(OFS_PRE, 32'h0000_0000);
    for (int e = 0; e < 4; e++) begin
      wr_reg(OFS_CTRL, DATA_W'(7 | (e << CTRL_EDGE)));
      rd_reg(OFS_CNT, c0);
      @(posedge clk);
      go <= 1'b1;
      half <= 4'(2 + $unsigned($random(seed)) % 4);
      @(posedge clk);
      go <= 1'b0;
      #1 n = 0;
      while (busy !== 1'b0 && n < 200) begin
        @(posedge clk);
        n++;
      end
      repeat (6) @(posedge clk);
      rd_reg(OFS_CNT, d);
      `CHK("events", 16'(ev_exp(e, 5)), 16'(d - c0))
    end
    rd_reg(OFS_CAP, c0);
    `CHK("capture", {16'h0000, 16'(d - 1)}, c0)
    rd_reg(OFS_STATUS, d);
    `CHK("capture flag", 1'b1, d[ST_CAP0])
    $display("test events done");
    wr_reg(OFS_CTRL, 32'h0000_0000);
    wr_reg(TMR_STRIDE + OFS_REF, DATA_W'(r));
    wr_reg(OFS_MASK, 32'h0000_0002);
    wr_reg(TMR_STRIDE + OFS_CTRL, 32'h0000_00ff);
    rd_reg(TMR_STRIDE + OFS_CTRL, d);
    `CHK("t1 ctrl", 32'h0000_0099, d)
    n = 0;
    repeat (4 * r + 4) begin
      @(posedge clk);
      #1 n += (pin_n !== 1'b1);
    end
    `CHK("t1 pin", 0, n)
    `CHK("t1 irq", 1'b1, irq)
    rd_reg(TMR_STRIDE + OFS_CAP, d);
    `CHK("t1 capture", 32'h0000_0000, d)
    rd_reg(TMR_STRIDE + OFS_PRE, d);
    `CHK("t1 prescale", {24'h00_0000, PRE_RST}, d)
    rd_reg(8'h80, d);
    `CHK("unmapped", 32'h0000_0000, d)
    wr_reg(TMR_STRIDE + OFS_CTRL, 32'h0000_0001);
    span(TMR_STRIDE + OFS_CNT, 65540, c);
    `CHK("wrap", 16'h0004, c)
    $display("test timer1 done");
    results();
  end
endmodule : tb
